// >>> core/iaa_pkg.sv
// package: register map, field positions and enumerations of the address/ack status block
package iaa_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_OWN = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 5'h18;
  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned B_ACK = 0;
  localparam int unsigned B_GCALL = 1;
  localparam int unsigned B_MATCH = 2;
  localparam int unsigned NFLAG = 2;
  localparam int unsigned C_ACK_CHECK_ENABLE = 0;
  localparam int unsigned C_TRS = 1;
  localparam int unsigned C_MST = 2;
  localparam int unsigned C_FSX = 3;
  localparam int unsigned O_FS = 0;
  localparam int unsigned O_ADDR_LSB = 1;
  localparam int unsigned O_ADDR_MSB = 7;
  localparam int unsigned I_MATCH = 0;
  localparam int unsigned I_GCALL = 1;
  localparam int unsigned I_ACK = 2;
  localparam int unsigned I_STOP = 3;
  localparam int unsigned IRQ_W = 4;
  // ****************************************
  // constants
  // ****************************************
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // decoded register select
  typedef enum {REG_STATUS, REG_CTRL, REG_OWN, REG_DATA, REG_IRQ_ST, REG_IRQ_CLR, REG_IRQ_EN, REG_NONE} iaa_reg_t;
  // link monitor states
  typedef enum {LNK_IDLE, LNK_DATA, LNK_ACK} iaa_lnk_t;
endpackage

// >>> core/iaa_if.sv
// interfaces: register access strobes and link monitor events
`timescale 1ns/1ps
interface iaa_reg_if;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [4:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slv(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_err, rd_data, rd_err);
  modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface

interface iaa_mon_if;
  logic start_p;
  logic stop_p;
  logic byte_p;
  logic first_p;
  logic [7:0] rx_byte;
  logic ack_p;
  logic ack_bit;
  logic ack_slot;
  modport src(output start_p, stop_p, byte_p, first_p, rx_byte, ack_p, ack_bit, ack_slot);
  modport dst(input start_p, stop_p, byte_p, first_p, rx_byte, ack_p, ack_bit, ack_slot);
endinterface

// >>> core/iaa_axil.sv
// module: axi4-lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
module iaa_axil import iaa_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register side
  iaa_reg_if.slv rif
);
  // ****************************************
  // write path
  // ****************************************
  logic [ADDR_W-1:0] aw_addr_reg; // held write address
  logic [31:0] w_data_reg; // held write data
  logic [3:0] w_strb_reg; // held byte enables
  // a ready flop low means its channel is holding an item
  assign rif.wr_en = !awready && !wready && !bvalid;
  assign rif.wr_addr = aw_addr_reg;
  assign rif.wr_data = w_data_reg;
  assign rif.wr_strb = w_strb_reg;
  // address and data are taken in either order, committed together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (rif.wr_en) begin
        bvalid <= 1'b1;
        bresp <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        // reopen both channels only once the response is gone
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end
  // ****************************************
  // read path
  // ****************************************
  assign rif.rd_en = arvalid && arready;
  assign rif.rd_addr = araddr;
  // data is captured at the address handshake, answered next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rif.rd_en) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rif.rd_data;
      rresp <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// >>> core/iaa_mon.sv
// module: two-wire pin sampler, start/stop detector and frame shifter
`timescale 1ns/1ps
module iaa_mon import iaa_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  // events
  iaa_mon_if.src mif
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic scl_s1_reg, scl_s2_reg, scl_d_reg; // scl sync chain and delayed copy
  logic sda_s1_reg, sda_s2_reg, sda_d_reg; // sda sync chain and delayed copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= {scl_i, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= {sda_i, sda_s1_reg, sda_s2_reg};
    end
  end
  // edges are taken only past the second stage
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_c = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_c = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
  // ****************************************
  // frame state machine
  // ****************************************
  iaa_lnk_t state_reg;
  logic [3:0] cnt_reg; // bits seen in this frame
  logic [7:0] sh_reg; // shift register, msb first
  logic first_reg; // frame is the first after a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= LNK_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      first_reg <= 1'b0;
      {mif.start_p, mif.stop_p, mif.byte_p, mif.ack_p} <= 4'h0;
      mif.first_p <= 1'b0;
      mif.rx_byte <= '0;
      mif.ack_bit <= 1'b0;
      mif.ack_slot <= 1'b0;
    end else begin
      {mif.start_p, mif.stop_p, mif.byte_p, mif.ack_p} <= 4'h0;
      // a repeated start restarts framing from any state
      if (start_c) begin
        mif.start_p <= 1'b1;
        state_reg <= LNK_DATA;
        cnt_reg <= '0;
        first_reg <= 1'b1;
        mif.ack_slot <= 1'b0;
      end else if (stop_c) begin
        mif.stop_p <= 1'b1;
        state_reg <= LNK_IDLE;
        mif.ack_slot <= 1'b0;
      end else begin
        case (state_reg)
          LNK_DATA: begin
            if (scl_rise && cnt_reg != BIT_ACK) begin
              sh_reg <= {sh_reg[6:0], sda_s2_reg};
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == BIT_LAST) begin
                mif.byte_p <= 1'b1;
                mif.first_p <= first_reg;
                mif.rx_byte <= {sh_reg[6:0], sda_s2_reg};
              end
            end else if (scl_fall && cnt_reg == BIT_ACK) begin
              state_reg <= LNK_ACK;
              mif.ack_slot <= 1'b1;
            end
          end
          LNK_ACK: begin
            if (scl_rise) begin
              mif.ack_p <= 1'b1;
              mif.ack_bit <= sda_s2_reg;
            end else if (scl_fall) begin
              state_reg <= LNK_DATA;
              cnt_reg <= '0;
              first_reg <= 1'b0;
              mif.ack_slot <= 1'b0;
            end
          end
          default: state_reg <= LNK_IDLE;
        endcase
      end
    end
  end
endmodule

// >>> core/iaa_top.sv
// module: address-match, general-call and acknowledge status of a two-wire bus interface
//
// Notes on behaviour
// - slave receive: own or general address sets match
// - match only sets while first format select is 0
// - match clears on data access, write-0, master
// - slave receive: all-zero first frame sets general-call; the code sets it only with fs or fsx clear
// - general-call clears on data access, write-0, master
// - general call with fs 1, fsx 0: no match
// - transmit with checking: received ack stored
// - writing check enable 0 clears acknowledge bit
// - receive: stored ack value driven onto bus
// - read ack: bus value if transmit, else programmed
// - writing ack always updates value returned when receiving
// - flags accept only written 0 to clear
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module iaa_top import iaa_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // interrupt
  output logic irq
);
  // ****************************************
  // sub-blocks
  // ****************************************
  iaa_reg_if rif ();
  iaa_mon_if mif ();
  iaa_axil u_axil (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .rif(rif)
  );
  iaa_mon u_mon (
    .aclk(aclk), .aresetn(aresetn),
    .scl_i(scl_i), .sda_i(sda_i),
    .mif(mif)
  );
  // ****************************************
  // address decode
  // ****************************************
  // shared by the read and the write path
  function automatic iaa_reg_t dec_reg(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_STATUS: dec_reg = REG_STATUS;
      OFS_CTRL: dec_reg = REG_CTRL;
      OFS_OWN: dec_reg = REG_OWN;
      OFS_DATA: dec_reg = REG_DATA;
      OFS_IRQ_ST: dec_reg = REG_IRQ_ST;
      OFS_IRQ_CLR: dec_reg = REG_IRQ_CLR;
      OFS_IRQ_EN: dec_reg = REG_IRQ_EN;
      default: dec_reg = REG_NONE;
    endcase
  endfunction
  iaa_reg_t wr_sel, rd_sel; // decoded targets
  logic wr_lo; // write reaches byte lane 0, where all fields live
  assign wr_sel = dec_reg(rif.wr_addr);
  assign rd_sel = dec_reg(rif.rd_addr);
  assign wr_lo = rif.wr_en && rif.wr_strb[0];
  assign rif.wr_err = (wr_sel == REG_NONE);
  assign rif.rd_err = (rd_sel == REG_NONE);
  // ****************************************
  // control registers
  // ****************************************
  logic ack_check_enable_reg; // ack check enable
  logic trs_reg; // transmit select
  logic mst_reg; // master mode
  logic fsx_reg; // second format select
  logic fs_reg; // first format select
  logic [6:0] own_addr_reg; // seven own-address bits
  logic [7:0] data_reg; // last received byte
  logic ctrl_wr, ack_check_enable_off; // control write, check enable written to 0
  assign ctrl_wr = wr_lo && wr_sel == REG_CTRL;
  assign ack_check_enable_off = ctrl_wr && !rif.wr_data[C_ACK_CHECK_ENABLE];
  // plain control fields, one write per register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {fsx_reg, mst_reg, trs_reg, ack_check_enable_reg} <= 4'h0;
      {own_addr_reg, fs_reg} <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        ack_check_enable_reg <= rif.wr_data[C_ACK_CHECK_ENABLE];
        trs_reg <= rif.wr_data[C_TRS];
        mst_reg <= rif.wr_data[C_MST];
        fsx_reg <= rif.wr_data[C_FSX];
      end
      if (wr_lo && wr_sel == REG_OWN) begin
        own_addr_reg <= rif.wr_data[O_ADDR_MSB:O_ADDR_LSB];
        fs_reg <= rif.wr_data[O_FS];
      end
    end
  end
  // received bytes land in the data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= 8'h00;
    end else if (mif.byte_p) begin
      data_reg <= mif.rx_byte;
    end
  end
  // ****************************************
  // address recognition
  // ****************************************
  logic slave_rx; // slave receive mode
  logic first_frame; // completed first frame after a start
  logic own_hit, gcall_hit; // frame compares
  logic match_set, gcall_set; // flag set strobes
  assign slave_rx = !trs_reg && !mst_reg;
  assign first_frame = mif.byte_p && mif.first_p && slave_rx;
  assign own_hit = mif.rx_byte[7:1] == own_addr_reg;
  // the whole frame, direction bit included, must be zero
  assign gcall_hit = mif.rx_byte == GCALL_ADDR;
  // only with first format select clear
  // fs 1 blocks the match even on a call
  assign match_set = first_frame && !fs_reg && (own_hit || gcall_hit);
  // general call with either select clear
  assign gcall_set = first_frame && gcall_hit && (!fs_reg || !fsx_reg);
  // ****************************************
  // sticky flags
  // ****************************************
  logic [NFLAG-1:0] flag_set; // index 0 general call, 1 match
  logic [NFLAG-1:0] flag_reg; // stored flags
  logic [NFLAG-1:0] seen_reg; // flag read as 1 since last set
  logic data_acc; // data register access that clears flags
  logic sts_wr, sts_rd; // status register write and read
  assign flag_set = {match_set, gcall_set};
  assign data_acc = (wr_lo && wr_sel == REG_DATA && trs_reg) || (rif.rd_en && rd_sel == REG_DATA && !trs_reg);
  assign sts_wr = wr_lo && wr_sel == REG_STATUS;
  assign sts_rd = rif.rd_en && rd_sel == REG_STATUS;
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      // a set in the clearing cycle wins, so no frame is lost
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flag_reg[gi] <= 1'b0;
          seen_reg[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flag_reg[gi] <= 1'b1;
          seen_reg[gi] <= 1'b0;
        // data access, written 0 after read, master
        // same clear set for the general call
        // a written 1 falls through and holds
        end else if (data_acc || mst_reg || (sts_wr && seen_reg[gi] && !rif.wr_data[B_GCALL + gi])) begin
          flag_reg[gi] <= 1'b0;
          seen_reg[gi] <= 1'b0;
        end else if (sts_rd && flag_reg[gi]) begin
          seen_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate
  // ****************************************
  // acknowledge bit
  // ****************************************
  logic ack_rx_reg; // acknowledge sampled while transmitting
  logic ack_sw_reg; // acknowledge to return while receiving
  logic ack_ev; // checked acknowledge arrived
  logic ack_rd; // value software reads back
  assign ack_ev = mif.ack_p && trs_reg && ack_check_enable_reg;
  // bus value in transmit, programmed value otherwise
  assign ack_rd = trs_reg ? ack_rx_reg : ack_sw_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_rx_reg <= 1'b0;
    // received ack, 1 sets and 0 clears
    end else if (ack_ev) begin
      ack_rx_reg <= mif.ack_bit;
    end else if (ack_check_enable_off) begin
      ack_rx_reg <= 1'b0;
    end
  end
  // read-modify-write hazard: a status write stores the ack bit it carries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_sw_reg <= 1'b0;
    // any status write updates it, either mode
    end else if (sts_wr) begin
      ack_sw_reg <= rif.wr_data[B_ACK];
    end else if (ack_check_enable_off) begin
      ack_sw_reg <= 1'b0;
    end
  end
  // ****************************************
  // acknowledge drive
  // ****************************************
  logic addressed_reg; // this device takes part in the transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addressed_reg <= 1'b0;
    end else if (mif.start_p || mif.stop_p) begin
      addressed_reg <= 1'b0;
    end else if (match_set) begin
      addressed_reg <= 1'b1;
    end
  end
  // the pin is only ever pulled low; a 1 means releasing it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      // stored value goes out as the acknowledge
      sda_oe <= mif.ack_slot && !trs_reg && (addressed_reg || mst_reg) && !ack_sw_reg;
      sda_o <= 1'b0;
    end
  end
  // ****************************************
  // interrupts
  // ****************************************
  logic [IRQ_W-1:0] irq_ev, irq_st_reg, irq_en_reg; // events, sticky status, enables
  always_comb begin
    irq_ev = '0;
    irq_ev[I_MATCH] = match_set;
    irq_ev[I_GCALL] = gcall_set;
    irq_ev[I_ACK] = ack_ev;
    irq_ev[I_STOP] = mif.stop_p;
  end
  // new events win over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_reg <= '0;
      irq_en_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_lo && wr_sel == REG_IRQ_CLR) begin
        irq_st_reg <= (irq_st_reg & ~rif.wr_data[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_st_reg <= irq_st_reg | irq_ev;
      end
      if (wr_lo && wr_sel == REG_IRQ_EN) begin
        irq_en_reg <= rif.wr_data[IRQ_W-1:0];
      end
      // one cycle behind the status, so the pin is a clean flop
      irq <= |(irq_st_reg & irq_en_reg);
    end
  end
  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rif.rd_data = '0;
    case (rd_sel)
      REG_STATUS: begin
        rif.rd_data[B_ACK] = ack_rd;
        rif.rd_data[B_GCALL] = flag_reg[0];
        rif.rd_data[B_MATCH] = flag_reg[1];
      end
      REG_CTRL: rif.rd_data[C_FSX:C_ACK_CHECK_ENABLE] = {fsx_reg, mst_reg, trs_reg, ack_check_enable_reg};
      REG_OWN: rif.rd_data[O_ADDR_MSB:O_FS] = {own_addr_reg, fs_reg};
      REG_DATA: rif.rd_data[7:0] = data_reg;
      REG_IRQ_ST: rif.rd_data[IRQ_W-1:0] = irq_st_reg;
      REG_IRQ_EN: rif.rd_data[IRQ_W-1:0] = irq_en_reg;
      default: rif.rd_data = '0;
    endcase
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_own_match_set: assert property (
    first_frame && !fs_reg && own_hit |=> flag_reg[1]
  ) else $error("own address frame did not set match flag");
  a_match_fs_gate: assert property (
    $rose(flag_reg[1]) |-> $past(!fs_reg && mif.byte_p)
  ) else $error("match flag rose without a frame and fs clear");
  a_master_clears: assert property (
    mst_reg |=> !flag_reg[1] && !flag_reg[0]
  ) else $error("flags survived master mode");
  a_gcall_set: assert property (
    first_frame && gcall_hit && !fsx_reg |=> flag_reg[0]
  ) else $error("general call did not set its flag");
  a_data_clear: assert property (
    data_acc && !first_frame |=> !flag_reg[0] && !flag_reg[1]
  ) else $error("data access did not clear flags");
  a_gcall_no_match: assert property (
    first_frame && gcall_hit && fs_reg && !fsx_reg && !flag_reg[1] |=> flag_reg[0] && !flag_reg[1]
  ) else $error("blocked general call set the match flag");
  a_ack_sampled: assert property (
    mif.ack_p && trs_reg && ack_check_enable_reg |=> ack_rx_reg == $past(mif.ack_bit)
  ) else $error("received acknowledge not stored");
  a_ack_check_enable_clear: assert property (
    ack_check_enable_off && !ack_ev && !sts_wr |=> !ack_rx_reg && !ack_sw_reg
  ) else $error("ack bit not cleared by check enable off");
  a_ack_drive: assert property (
    sda_oe |-> $past(mif.ack_slot && !trs_reg && !ack_sw_reg)
  ) else $error("sda driven outside a receive ack slot");
  a_ack_readback: assert property (
    sts_rd |=> rvalid && rdata[B_ACK] == $past(trs_reg ? ack_rx_reg : ack_sw_reg)
  ) else $error("ack readback picked the wrong source");
  a_ack_write: assert property (
    sts_wr |=> ack_sw_reg == $past(rif.wr_data[B_ACK])
  ) else $error("ack write did not update returned value");
  a_one_holds: assert property (
    sts_wr && rif.wr_data[B_MATCH] && flag_reg[1] && !data_acc && !mst_reg |=> flag_reg[1]
  ) else $error("written 1 cleared the match flag");
endmodule

// >>> tb/iaa_bus_model.sv
// two-wire bus master model for the link pins
`timescale 1ns/1ps
module iaa_bus_model (
  // link pins
  output logic scl,
  output logic sda_m,
  input wire logic sda_w
);
  // idle bus: both lines released, pulled high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // one bit, 800 ns: data moves only while the clock is low
  task automatic bit_out(input logic b, output logic s);
    sda_m = b;
    #200 scl = 1'b1;
    #200 s = sda_w;
    #200 scl = 1'b0;
    #200;
  endtask
  // start: data falls while the clock is high
  task automatic start();
    #400 sda_m = 1'b0;
    #400 scl = 1'b0;
    #200;
  endtask
  // byte msb first, then the ninth clock; drv 1 leaves data released
  task automatic xfer(input logic [7:0] b, input logic drv, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i], s);
    end
    bit_out(drv, ack);
    // the device lets go of its acknowledge a few clocks late
    #400;
  endtask
  // stop: data rises while the clock is high, clock then stands still
  task automatic stop();
    sda_m = 1'b0;
    #200 scl = 1'b1;
    #400 sda_m = 1'b1;
    #400;
  endtask
endmodule

// >>> tb/iaa_top_tb_top.sv
// testbench: register and link scenarios of the status block
`timescale 1ns/1ps
module iaa_top_tb_top import iaa_pkg::*; ;
  // ****
  // stimulus and dut
  // ****
  logic aclk = 1'b0, aresetn = 1'b0, bready = 1'b1, rready = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, irq, scl, sda_m, sda_w, ak;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] exp_q[$];
  logic [6:0] own;
  int n_fail = 0, checked = 0, seed = 63;
  // open-drain data wire with pull-up: while enabled the device puts its sda_o level on it
  assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
  iaa_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .scl_i(scl),
    .sda_i(sda_w), .sda_o, .sda_oe, .irq);
  iaa_bus_model m (.scl, .sda_m, .sda_w);
  initial forever #50 aclk = ~aclk;
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_of_test();
    // notes never answered count as mismatches
    n_fail += exp_q.size();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****
  // bus tasks
  // ****
  task wr(input logic [4:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    // only the aligned offsets up to the enable register are mapped
    chk("bresp", (a > OFS_IRQ_EN) ? 34'(RESP_SLVERR) : 34'(RESP_OKAY), 34'(bresp));
  endtask
  // the note goes on the queue before the request leaves
  task rd(input logic [4:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask
  task frame(input logic [7:0] b, input logic d);
    m.start();
    m.xfer(b, d, ak);
    m.stop();
  endtask
  // watcher: oldest note against each read answer
  always @(posedge aclk) begin
    if (rvalid && rready && exp_q.size() > 0) begin
      chk("rdata", exp_q.pop_front(), {rresp, rdata});
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    own = 7'($random(seed)) | 7'h01;
    rd(OFS_STATUS, 34'h0);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_OWN, {24'h0, own, 1'b0});
    frame({own, 1'b0}, 1'b1);
    chk("bus_ack", 34'h0, 34'(ak));
    chk("irq", 34'h1, 34'(irq));
    rd(OFS_STATUS, 34'h4);
    wr(OFS_STATUS, 32'h6);
    rd(OFS_STATUS, 34'h4);
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 34'h0);
    frame(8'h00, 1'b1);
    chk("bus_ack", 34'h0, 34'(ak));
    rd(OFS_STATUS, 34'h6);
    rd(OFS_DATA, 34'h0);
    rd(OFS_STATUS, 34'h0);
    wr(OFS_IRQ_CLR, 32'hF);
    wr(OFS_OWN, {24'h0, own, 1'b1});
    frame(8'h00, 1'b1);
    chk("bus_ack", 34'h1, 34'(ak));
    chk("irq", 34'h0, 34'(irq));
    rd(OFS_STATUS, 34'h2);
    rd(OFS_IRQ_ST, 34'hA);
    wr(OFS_CTRL, 32'h4);
    rd(OFS_STATUS, 34'h0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_OWN, {24'h0, own, 1'b0});
    wr(OFS_STATUS, 32'h1);
    frame({own, 1'b0}, 1'b1);
    chk("bus_ack", 34'h1, 34'(ak));
    rd(OFS_STATUS, 34'h5);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_CTRL, 32'h3);
    m.start();
    m.xfer(8'hA5, 1'b1, ak);
    rd(OFS_STATUS, 34'h1);
    m.xfer(8'h5A, 1'b0, ak);
    rd(OFS_STATUS, 34'h0);
    m.xfer(8'hC3, 1'b1, ak);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_STATUS, 34'h0);
    m.stop();
    wr(5'h1C, 32'hFF);
    rd(5'h1C, 34'h200000000);
    // let the watcher take the last answer before the verdict
    @(posedge aclk);
    end_of_test();
  end
  // watchdog well past the expected run length
  initial begin
    #500000;
    n_fail++;
    end_of_test();
  end
endmodule
